/* File: hw/dcc_pkg.sv */
// Purpose: Shared constants and types for the DMA channel control block
// Assumes: Four channels, 32-bit classic Wishbone register access
// Notes: Register offsets are byte addresses
package dcc_pkg;
    localparam int DCC_NCH = 4;
    localparam int DCC_NEXT = 2;
    localparam int DCC_NPER = 10;
    localparam int DCC_CNT_W = 24;
    // Register map, per channel block of 16 bytes
    localparam logic [3:0] DCC_OFF_CTRL = 4'h0;
    localparam logic [3:0] DCC_OFF_SRC = 4'h4;
    localparam logic [3:0] DCC_OFF_CNT = 4'h8;
    // Control field positions
    localparam int DCC_B_DE = 0;
    localparam int DCC_B_TE = 1;
    localparam int DCC_B_IE = 2;
    localparam int DCC_B_SIZE = 3;
    localparam int DCC_B_BUS = 5;
    localparam int DCC_B_SENSE = 6;
    localparam int DCC_B_RSEL = 8;
    localparam int DCC_B_STEP = 12;
    localparam int DCC_B_DI = 20;
    // Writable bits: common, sense (ch 0/1), pointer mode (ch 3)
    localparam logic [31:0] DCC_WM_BASE = 32'h0000_3f3d;
    localparam logic [31:0] DCC_WM_SENSE = 32'h0000_0040;
    localparam logic [31:0] DCC_WM_DI = 32'h0010_0000;
    // Reset values
    localparam logic [31:0] DCC_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] DCC_SRC_RST = 32'h0000_0000;
    localparam logic [DCC_CNT_W-1:0] DCC_CNT_RST = 24'h00_0000;
    // Request source codes
    localparam logic [3:0] DCC_RS_EXT_DUAL = 4'h0;
    localparam logic [3:0] DCC_RS_BAD1 = 4'h1;
    localparam logic [3:0] DCC_RS_EXT_OUT = 4'h2;
    localparam logic [3:0] DCC_RS_EXT_IN = 4'h3;
    localparam logic [3:0] DCC_RS_AUTO = 4'h4;
    localparam logic [3:0] DCC_RS_BAD5 = 4'h5;
    localparam logic [3:0] DCC_RS_PER0 = 4'h6;
    // Step and size codes
    localparam logic [1:0] DCC_STEP_FIX = 2'h0;
    localparam logic [1:0] DCC_STEP_INC = 2'h1;
    localparam logic [1:0] DCC_STEP_DEC = 2'h2;
    localparam logic [1:0] DCC_STEP_BAD = 2'h3;
    localparam logic [1:0] DCC_SIZE_BAD = 2'h3;
    localparam logic [31:0] DCC_IND_STEP = 32'h0000_0004;
    typedef enum logic {DCC_IDLE, DCC_XFER} dcc_state_e;
endpackage

/* File: hw/dcc_step_if.sv */
// Purpose: Carries the source pointer step request and result
// Assumes: One transfer unit in flight at a time
// Notes: Purely combinational link
`timescale 1ns/100ps
interface dcc_step_if;
    logic [31:0] ptr;
    logic [1:0] step;
    logic [1:0] size;
    logic indirect;
    logic hold;
    logic [31:0] next_ptr;
    modport calc (input ptr, step, size, indirect, hold, output next_ptr);
    modport user (output ptr, step, size, indirect, hold, input next_ptr);
endinterface

/* File: hw/dcc_src_step.sv */
// Purpose: Next source pointer after one transfer unit
// Assumes: Prohibited step and size codes never reach a transfer
// Notes: Indirect pointer steps by a fixed four bytes
`timescale 1ns/100ps
module dcc_src_step
    import dcc_pkg::*;
(
    dcc_step_if.calc st
);
    logic [31:0] amount;

    always_comb begin
        if (st.indirect) begin
            amount = DCC_IND_STEP;
        end else begin
            amount = 32'h0000_0001 << st.size;
        end
        if (st.hold) begin
            st.next_ptr = st.ptr;
        end else begin
            case (st.step)
                DCC_STEP_INC: st.next_ptr = st.ptr + amount;
                DCC_STEP_DEC: st.next_ptr = st.ptr - amount;
                default: st.next_ptr = st.ptr;
            endcase
        end
    end
endmodule

/* File: hw/dcc_pin_sense.sv */
// Purpose: Synchronise the external request pins and find their falling edges
// Assumes: Pins are active low and idle high
// Notes: A level counts once the second and third stages agree
`timescale 1ns/100ps
module dcc_pin_sense
    import dcc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [DCC_NEXT-1:0] pin_n_i,
    output logic [DCC_NEXT-1:0] low_o,
    output logic [DCC_NEXT-1:0] fell_o
);
    logic [DCC_NEXT-1:0] s1;
    logic [DCC_NEXT-1:0] s2;
    logic [DCC_NEXT-1:0] s3;
    logic [DCC_NEXT-1:0] stable;
    logic [DCC_NEXT-1:0] prev;
    logic [DCC_NEXT-1:0] next_stable;

    genvar g;
    generate
        for (g = 0; g < DCC_NEXT; g = g + 1) begin : g_pin
            always_comb begin
                next_stable[g] = (s2[g] == s3[g]) ? s3[g] : stable[g];
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    s1[g] <= 1'b1;
                    s2[g] <= 1'b1;
                    s3[g] <= 1'b1;
                    stable[g] <= 1'b1;
                    prev[g] <= 1'b1;
                end else begin
                    s1[g] <= pin_n_i[g];
                    s2[g] <= s1[g];
                    s3[g] <= s2[g];
                    stable[g] <= next_stable[g];
                    prev[g] <= stable[g];
                end
            end
            assign low_o[g] = ~stable[g];
            assign fell_o[g] = prev[g] & ~stable[g];
        end
    endgenerate
endmodule

/* File: hw/dcc_top.sv */
// Purpose: Control logic of a four-channel DMA controller
// Assumes: Transfer engine outside executes each unit and pulses done
// Notes: Fixed priority channel 0 first; one unit in flight at a time
`timescale 1ns/100ps
module dcc_top
    import dcc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic standby_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic master_enable_i,
    input wire logic nmi_abort_flag_i,
    input wire logic address_error_flag_i,
    input wire logic [DCC_NEXT-1:0] ext_request_pin_n_i,
    input wire logic [DCC_NPER-1:0] periph_req_n_i,
    output logic xfer_valid_o,
    output logic [1:0] xfer_channel_o,
    output logic [31:0] xfer_src_addr_o,
    output logic [1:0] xfer_size_o,
    output logic [1:0] xfer_addr_mode_o,
    output logic xfer_burst_o,
    output logic xfer_indirect_o,
    input wire logic xfer_done_i,
    output logic [DCC_NCH-1:0] irq_o,
    output logic [DCC_NCH-1:0] channel_ready_o
);
    logic [31:0] ctrl [DCC_NCH];
    logic [31:0] src_ptr [DCC_NCH];
    logic [DCC_CNT_W-1:0] cnt [DCC_NCH];
    logic [DCC_NCH-1:0] te_seen;
    logic [DCC_NCH-1:0] pend;
    logic [DCC_NPER-1:0] per_prev;
    dcc_state_e state;
    logic [1:0] cur;
    logic ack;
    logic [31:0] rdata;

    logic [31:0] next_ctrl [DCC_NCH];
    logic [31:0] next_src_ptr [DCC_NCH];
    logic [DCC_CNT_W-1:0] next_cnt [DCC_NCH];
    logic [DCC_NCH-1:0] next_te_seen;
    logic [DCC_NCH-1:0] next_pend;
    dcc_state_e next_state;
    logic [1:0] next_cur;
    logic next_ack;
    logic [31:0] next_rdata;

    logic [DCC_NEXT-1:0] ext_low;
    logic [DCC_NEXT-1:0] ext_fell;
    logic [DCC_NPER-1:0] per_fell;
    logic [DCC_NCH-1:0] ready;
    logic [DCC_NCH-1:0] edge_req;
    logic [DCC_NCH-1:0] want;
    logic [31:0] lane_mask;
    logic access;
    logic [DCC_CNT_W-1:0] cnt_dec;

    dcc_step_if stp ();

    dcc_pin_sense u_pins (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_n_i(ext_request_pin_n_i),
        .low_o(ext_low),
        .fell_o(ext_fell)
    );

    dcc_src_step u_step (
        .st(stp)
    );

    function automatic logic [31:0] wr_mask(input logic [1:0] ch);
        logic [31:0] m;
        m = DCC_WM_BASE;
        if (ch < 2'd2) begin
            m = m | DCC_WM_SENSE;
        end
        if (ch == 2'd3) begin
            m = m | DCC_WM_DI;
        end
        return m;
    endfunction

    function automatic logic cfg_ok(input logic [1:0] ch,
                                    input logic [31:0] c);
        logic [3:0] rs;
        logic ok;
        rs = c[DCC_B_RSEL +: 4];
        ok = (c[DCC_B_STEP +: 2] != DCC_STEP_BAD)
             && (c[DCC_B_SIZE +: 2] != DCC_SIZE_BAD)
             && (rs != DCC_RS_BAD1) && (rs != DCC_RS_BAD5);
        if (ch >= 2'd2 && (rs == DCC_RS_EXT_DUAL || rs == DCC_RS_EXT_OUT
                           || rs == DCC_RS_EXT_IN)) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    // Peripheral strobes come from this clock, so no synchroniser
    assign per_fell = per_prev & ~periph_req_n_i;
    assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                        {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign access = wb_cyc_i & wb_stb_i & ~ack;

    always_comb begin
        for (int c = 0; c < DCC_NCH; c++) begin
            logic [3:0] rs;
            rs = ctrl[c][DCC_B_RSEL +: 4];
            ready[c] = ctrl[c][DCC_B_DE] & master_enable_i
                       & ~ctrl[c][DCC_B_TE]
                       & ~nmi_abort_flag_i & ~address_error_flag_i
                       & cfg_ok(2'(c), ctrl[c]);
            edge_req[c] = 1'b0;
            want[c] = 1'b0;
            if (rs == DCC_RS_AUTO) begin
                want[c] = ready[c];
            end else if (rs >= DCC_RS_PER0) begin
                edge_req[c] = per_fell[4'(rs - DCC_RS_PER0)];
                want[c] = ready[c] & pend[c];
            end else if (c < DCC_NEXT) begin
                if (ctrl[c][DCC_B_SENSE]) begin
                    edge_req[c] = ext_fell[c];
                    want[c] = ready[c] & pend[c];
                end else begin
                    want[c] = ready[c] & (ext_low[c] | pend[c]);
                end
            end
        end
    end

    always_comb begin
        stp.ptr = src_ptr[cur];
        stp.step = ctrl[cur][DCC_B_STEP +: 2];
        stp.size = ctrl[cur][DCC_B_SIZE +: 2];
        stp.indirect = (cur == 2'd3) && ctrl[cur][DCC_B_DI];
        stp.hold = ctrl[cur][DCC_B_RSEL +: 4] == DCC_RS_EXT_IN;
    end

    assign cnt_dec = cnt[cur] - 1'b1;

    always_comb begin
        logic [1:0] ch;
        logic [3:0] off;
        logic [31:0] wm;
        ch = wb_adr_i[5:4];
        off = wb_adr_i[3:0];
        wm = wr_mask(ch) & lane_mask;
        for (int c = 0; c < DCC_NCH; c++) begin
            next_ctrl[c] = ctrl[c];
            next_src_ptr[c] = src_ptr[c];
            next_cnt[c] = cnt[c];
        end
        next_te_seen = te_seen;
        next_pend = pend;
        next_state = state;
        next_cur = cur;
        next_ack = access;
        next_rdata = rdata;

        // Software side first, so hardware events below win
        if (access) begin
            next_rdata = 32'h0000_0000;
            if (wb_adr_i[7:6] == 2'b00) begin
                case (off)
                    DCC_OFF_CTRL: begin
                        next_rdata = ctrl[ch];
                        if (!wb_we_i && ctrl[ch][DCC_B_TE]) begin
                            next_te_seen[ch] = 1'b1;
                        end
                        if (wb_we_i) begin
                            next_ctrl[ch] = (ctrl[ch] & ~wm) | (wb_dat_i & wm);
                            next_ctrl[ch][DCC_B_TE] = ctrl[ch][DCC_B_TE];
                            if (wb_sel_i[0] && !wb_dat_i[DCC_B_TE]
                                && te_seen[ch]) begin
                                next_ctrl[ch][DCC_B_TE] = 1'b0;
                                next_te_seen[ch] = 1'b0;
                            end
                        end
                    end
                    DCC_OFF_SRC: begin
                        next_rdata = src_ptr[ch];
                        if (wb_we_i) begin
                            next_src_ptr[ch] = (src_ptr[ch] & ~lane_mask)
                                               | (wb_dat_i & lane_mask);
                        end
                    end
                    DCC_OFF_CNT: begin
                        next_rdata = {8'h00, cnt[ch]};
                        if (wb_we_i) begin
                            next_cnt[ch] = (cnt[ch] & ~lane_mask[23:0])
                                           | (wb_dat_i[23:0] & lane_mask[23:0]);
                        end
                    end
                    default: next_rdata = 32'h0000_0000;
                endcase
            end
        end

        // Requests are only caught once the channel is ready
        for (int c = 0; c < DCC_NCH; c++) begin
            if (!ready[c]) begin
                next_pend[c] = 1'b0;
            end
        end

        case (state)
            DCC_IDLE: begin
                for (int c = DCC_NCH - 1; c >= 0; c--) begin
                    if (want[c]) begin
                        next_state = DCC_XFER;
                        next_cur = 2'(c);
                    end
                end
            end
            DCC_XFER: begin
                if (!ready[cur]) begin
                    next_state = DCC_IDLE;
                end else if (xfer_done_i) begin
                    next_src_ptr[cur] = stp.next_ptr;
                    next_cnt[cur] = cnt_dec;
                    if (!ctrl[cur][DCC_B_BUS]) begin
                        next_pend[cur] = 1'b0;
                        next_state = DCC_IDLE;
                    end
                    if (cnt_dec == DCC_CNT_RST) begin
                        next_ctrl[cur][DCC_B_TE] = 1'b1;
                        next_pend[cur] = 1'b0;
                        next_state = DCC_IDLE;
                    end
                end
            end
            default: next_state = DCC_IDLE;
        endcase

        for (int c = 0; c < DCC_NCH; c++) begin
            if (ready[c] && edge_req[c]) begin
                next_pend[c] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || standby_i) begin
            for (int c = 0; c < DCC_NCH; c++) begin
                ctrl[c] <= DCC_CTRL_RST;
                src_ptr[c] <= DCC_SRC_RST;
                cnt[c] <= DCC_CNT_RST;
            end
            te_seen <= '0;
            pend <= '0;
            per_prev <= '1;
            state <= DCC_IDLE;
            cur <= 2'h0;
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            for (int c = 0; c < DCC_NCH; c++) begin
                ctrl[c] <= next_ctrl[c];
                src_ptr[c] <= next_src_ptr[c];
                cnt[c] <= next_cnt[c];
            end
            te_seen <= next_te_seen;
            pend <= next_pend;
            per_prev <= periph_req_n_i;
            state <= next_state;
            cur <= next_cur;
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;
    // Drops in the same cycle the channel loses its enable
    assign xfer_valid_o = (state == DCC_XFER) && ready[cur];
    assign xfer_channel_o = cur;
    assign xfer_src_addr_o = src_ptr[cur];
    assign xfer_size_o = ctrl[cur][DCC_B_SIZE +: 2];
    assign xfer_burst_o = ctrl[cur][DCC_B_BUS];
    assign xfer_addr_mode_o = (ctrl[cur][DCC_B_RSEL + 1 +: 3] == 3'h1)
                              ? ctrl[cur][DCC_B_RSEL +: 2] : 2'h0;
    assign xfer_indirect_o = stp.indirect;
    assign channel_ready_o = ready;

    genvar g;
    generate
        for (g = 0; g < DCC_NCH; g = g + 1) begin : g_irq
            assign irq_o[g] = ctrl[g][DCC_B_TE] & ctrl[g][DCC_B_IE];
        end
    endgenerate
endmodule

/* File: dv/dcc_engine_model.sv */
// Purpose: Transfer engine beside the block, one unit per valid request
// Assumes: Bench sets the latency per unit, 0 to 15, so done comes 1 to 16 cycles after valid
// Notes: Done is a one-cycle pulse; a withdrawn unit is abandoned
`timescale 1ns/100ps
module dcc_engine_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic valid_i,
    input wire logic [3:0] lat_i,
    output logic done_o
);
    logic [3:0] cnt;
    // Restart the wait when the unit is withdrawn
    always_ff @(posedge clk_i) begin
        if (rst_i || !valid_i || done_o) begin
            cnt <= 4'h0;
            done_o <= 1'b0;
        end else if (cnt == lat_i) begin
            done_o <= 1'b1;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

/* File: dv/dcc_top_sva.sv */
// Purpose: Port-level checks for the DMA channel control block
// Assumes: One clock domain, synchronous active-high reset
// Notes: Pointer steps are judged only on back-to-back burst units
`timescale 1ns/100ps
module dcc_top_sva
    import dcc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic standby_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire logic master_enable_i,
    input wire logic nmi_abort_flag_i,
    input wire logic address_error_flag_i,
    input wire logic xfer_valid_o,
    input wire logic [1:0] xfer_channel_o,
    input wire logic [31:0] xfer_src_addr_o,
    input wire logic [1:0] xfer_size_o,
    input wire logic [1:0] xfer_addr_mode_o,
    input wire logic xfer_burst_o,
    input wire logic xfer_indirect_o,
    input wire logic xfer_done_i,
    input wire logic [DCC_NCH-1:0] irq_o,
    input wire logic [DCC_NCH-1:0] channel_ready_o
);
    logic [31:0] unit_b;
    logic wr;
    assign unit_b = xfer_indirect_o ? 32'h4 : (32'h1 << xfer_size_o);
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence unit_taken;
        xfer_valid_o && xfer_burst_o && xfer_done_i;
    endsequence
    sequence same_channel;
        xfer_valid_o && xfer_channel_o == $past(xfer_channel_o);
    endsequence
    step_size_a: assert property (
        unit_taken ##1 same_channel |-> (xfer_src_addr_o -
        $past(xfer_src_addr_o)) inside {32'h0, $past(unit_b), -$past(unit_b)})
        else $error("source pointer stepped by a wrong amount");
    dev_fixed_a: assert property (
        unit_taken ##1 same_channel |->
        $past(xfer_addr_mode_o) != 2'h3 || $stable(xfer_src_addr_o))
        else $error("pointer moved on device to memory transfer");
    valid_ready_a: assert property (
        xfer_valid_o |-> channel_ready_o[xfer_channel_o]
        && !irq_o[xfer_channel_o])
        else $error("unit offered on a channel that is not ready");
    gate_inputs_a: assert property (
        !master_enable_i || nmi_abort_flag_i || address_error_flag_i
        |-> channel_ready_o == '0 && !xfer_valid_o)
        else $error("channel ready despite global gating");
    steal_release_a: assert property (
        xfer_valid_o && !xfer_burst_o && xfer_done_i |=> !xfer_valid_o)
        else $error("cycle steal kept the bus after a unit");
    size_legal_a: assert property (
        xfer_valid_o |-> xfer_size_o != DCC_SIZE_BAD)
        else $error("unit offered with prohibited size");
    ext_low_ch_a: assert property (
        xfer_valid_o && xfer_channel_o[1] |-> xfer_addr_mode_o == 2'h0)
        else $error("single address mode on channel 2 or 3");
    indirect_ch3_a: assert property (
        xfer_valid_o && xfer_indirect_o |-> xfer_channel_o == 2'h3)
        else $error("indirect unit outside channel 3");
    irq_cause_a: assert property (
        |(irq_o & ~$past(irq_o)) |-> $past(xfer_done_i && xfer_valid_o)
        || $past(wr))
        else $error("interrupt rose without a finished unit");
    irq_clear_a: assert property (
        |($past(irq_o) & ~irq_o) |-> $past(wr) || $past(standby_i))
        else $error("interrupt fell without a write or standby");
    ack_timing_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus acknowledge not a single-cycle answer");
endmodule

/* File: dv/dcc_top_test.sv */
// Purpose: Self-checking bench for the DMA channel control block
// Assumes: Engine model answers each unit after a random latency
// Notes: One channel active at a time, so priority is not exercised
`timescale 1ns/100ps
module dcc_top_test
    import dcc_pkg::*;
;
    logic clk_i = 0, rst_i = 1, standby_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
    logic wb_we_i = 0, master_enable_i = 0, nmi_abort_flag_i = 0;
    logic address_error_flag_i = 0, wb_ack_o, req_on = 0, lvl_mode = 0;
    logic use_per = 0, xfer_valid_o, xfer_burst_o, xfer_indirect_o;
    logic xfer_done_i, bm, ds, di;
    logic [7:0] wb_adr_i = 0, a;
    logic [31:0] wb_dat_i = 0, wb_dat_o, xfer_src_addr_o, rd, ctl, src;
    logic [3:0] wb_sel_i = 4'hf, lat = 0, per_idx = 0, rs;
    logic [2:0] ph = 0;
    logic [1:0] cur_ch = 0, ch, sz, stp, md;
    logic [1:0] xfer_channel_o, xfer_size_o, xfer_addr_mode_o;
    logic [DCC_NEXT-1:0] ext_request_pin_n_i = '1;
    logic [DCC_NPER-1:0] periph_req_n_i = '1;
    logic [DCC_NCH-1:0] irq_o, channel_ready_o;
    int errors = 0, samples_checked = 0, cnt, k;
    wire req_lo = req_on && (lvl_mode || ph[2]);
    dcc_top dcc_top_inst (.clk_i, .rst_i, .standby_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o,
        .master_enable_i, .nmi_abort_flag_i, .address_error_flag_i,
        .ext_request_pin_n_i, .periph_req_n_i, .xfer_valid_o, .xfer_channel_o,
        .xfer_src_addr_o, .xfer_size_o, .xfer_addr_mode_o, .xfer_burst_o,
        .xfer_indirect_o, .xfer_done_i, .irq_o, .channel_ready_o);
    dcc_engine_model dcc_engine_model_inst (.clk_i, .rst_i,
        .valid_i(xfer_valid_o), .lat_i(lat), .done_o(xfer_done_i));
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    // Level mode holds the pin low; edge kinds toggle every 4 cycles
    always @(posedge clk_i) begin
        ph <= ph + 3'h1;
        ext_request_pin_n_i <= ~({DCC_NEXT{req_lo && !use_per}}
            & (2'h1 << cur_ch));
        periph_req_n_i <= ~({DCC_NPER{req_lo && use_per}}
            & (10'h1 << per_idx));
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic fail_wait();
        errors++;
        $display("mismatch at %0t: wait ran out", $time);
        summarize();
    endtask
    task automatic wb(input logic we, input logic [7:0] ad,
                      input logic [31:0] d);
        int i;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= ad;
        wb_dat_i <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        if (i == 20) fail_wait();
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
        wb(1'b0, ad, 32'h0);
        check(rd, exp);
    endtask
    task automatic wait_unit();
        int i;
        for (i = 0; i < 80; i++) begin
            @(negedge clk_i);
            if (xfer_valid_o === 1'b1 && xfer_done_i === 1'b1) break;
        end
        if (i == 80) fail_wait();
    endtask
    function automatic logic [31:0] step_of(input logic [1:0] s,
        input logic [1:0] z, input logic i);
        logic [31:0] u;
        u = i ? 32'h4 : (32'h1 << z);
        return s == DCC_STEP_INC ? u : (s == DCC_STEP_DEC ? -u : 32'h0);
    endfunction
    // Prohibited settings: ext codes on ch2/3, codes 1 and 5, size/step 11
    logic [39:0] bad [7] = '{40'h20_0000_0001, 40'h20_0000_0201,
        40'h30_0000_0301, 40'h00_0000_0101, 40'h00_0000_0501,
        40'h00_0000_0419, 40'h10_0000_3401};
    initial begin
        k = $urandom(32'hb2ca);
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            a = 8'(c * 16);
            rdchk(a, DCC_CTRL_RST);
            wb(1'b1, a, 32'hffff_ffff);
            rdchk(a, DCC_WM_BASE | (c < 2 ? DCC_WM_SENSE : 32'h0)
                | (c == 3 ? DCC_WM_DI : 32'h0));
            wb(1'b1, a, 32'h0);
        end
        rdchk(8'h40, 32'h0);
        master_enable_i <= 1'b1;
        foreach (bad[j]) begin
            wb(1'b1, bad[j][39:32], bad[j][31:0]);
            repeat (3) @(negedge clk_i);
            check({27'h0, xfer_valid_o, channel_ready_o}, 0);
            wb(1'b1, bad[j][39:32], 32'h0);
        end
        for (int it = 0; it < 24; it++) begin
            ch = 2'($urandom_range(3));
            sz = 2'($urandom_range(2));
            stp = 2'($urandom_range(2));
            bm = 1'($urandom_range(1));
            di = ch == 2'h3 && $urandom_range(1);
            ds = ch < 2'h2 && $urandom_range(1);
            k = $urandom_range(5);
            rs = (ch < 2 && k < 3) ? 4'(k == 0 ? 0 : k + 1) : (k == 3 ?
                DCC_RS_AUTO : 4'(6 + $urandom_range(9)));
            md = (rs == 4'h2 || rs == 4'h3) ? rs[1:0] : 2'h0;
            cnt = $urandom_range(1, 4);
            src = $urandom;
            a = {ch, 4'h0};
            ctl = 32'h5 | 32'(sz) << 3 | 32'(bm) << 5 | 32'(ds) << 6
                | 32'(rs) << 8 | 32'(stp) << 12 | 32'(di) << 20;
            wb(1'b1, a + 8'h4, src);
            wb(1'b1, a + 8'h8, 32'(cnt));
            lat <= 4'($urandom_range(3));
            cur_ch <= ch;
            use_per <= rs >= 4'h6;
            per_idx <= rs - 4'h6;
            lvl_mode <= rs < 4'h4 && !ds;
            wb(1'b1, a, ctl);
            if (rs != DCC_RS_AUTO) begin
                repeat (6) @(negedge clk_i);
                check({31'h0, xfer_valid_o}, 0);
                @(posedge clk_i);
                req_on <= 1'b1;
            end
            for (int u = 0; u < cnt; u++) begin
                wait_unit();
                check(xfer_src_addr_o, src);
                check({ch, sz, bm, di, md}, {xfer_channel_o, xfer_size_o,
                    xfer_burst_o, xfer_indirect_o, xfer_addr_mode_o});
                if (md != 2'h3) src = src + step_of(stp, sz, di);
                @(posedge clk_i);
            end
            req_on <= 1'b0;
            repeat (2) @(negedge clk_i);
            check({28'h0, irq_o}, 32'h1 << ch);
            check({28'h0, channel_ready_o}, 0);
            rdchk(a + 8'h8, 32'h0);
            wb(1'b1, a, ctl);
            rdchk(a, ctl | 32'h2);
            wb(1'b1, a, ctl & ~32'h3);
            rdchk(a, ctl & ~32'h3);
        end
        lat <= 4'h2;
        wb(1'b1, 8'h14, 32'h100);
        wb(1'b1, 8'h18, 32'h5);
        wb(1'b1, 8'h10, 32'h1435);
        wait_unit();
        for (int f = 0; f < 3; f++) begin
            @(posedge clk_i);
            {master_enable_i, nmi_abort_flag_i, address_error_flag_i} <=
                3'h4 ^ (3'h1 << f);
            repeat (2) @(negedge clk_i);
            check({27'h0, xfer_valid_o, channel_ready_o}, 0);
        end
        wb(1'b1, 8'h10, 32'h1434);
        master_enable_i <= 1'b1;
        rdchk(8'h18, 32'h4);
        rdchk(8'h14, 32'h104);
        rdchk(8'h10, 32'h1434);
        // Only the enabled byte lane may change
        wb_sel_i <= 4'h2;
        wb(1'b1, 8'h14, 32'hffff_ffff);
        wb_sel_i <= 4'hf;
        rdchk(8'h14, 32'h0000_ff04);
        // Device to memory burst: pointer must hold whatever the step
        wb(1'b1, 8'h04, 32'h200);
        wb(1'b1, 8'h08, 32'h2);
        cur_ch <= 2'h0;
        use_per <= 1'b0;
        lvl_mode <= 1'b1;
        req_on <= 1'b1;
        wb(1'b1, 8'h00, 32'h1325);
        for (int u = 0; u < 2; u++) begin
            wait_unit();
            check(xfer_src_addr_o, 32'h200);
            @(posedge clk_i);
        end
        req_on <= 1'b0;
        rdchk(8'h08, 32'h0);
        rdchk(8'h04, 32'h200);
        @(posedge clk_i);
        standby_i <= 1'b1;
        @(posedge clk_i);
        standby_i <= 1'b0;
        rdchk(8'h10, 32'h0);
        summarize();
    end
endmodule
bind dcc_top dcc_top_sva dcc_top_sva_inst (.clk_i, .rst_i, .standby_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .master_enable_i,
    .nmi_abort_flag_i, .address_error_flag_i, .xfer_valid_o, .xfer_channel_o,
    .xfer_src_addr_o, .xfer_size_o, .xfer_addr_mode_o, .xfer_burst_o,
    .xfer_indirect_o, .xfer_done_i, .irq_o, .channel_ready_o);
